// ### pkg/idg_pkg.sv
package idg_pkg;

  // ----------------------------------------------------------------
  // register map, byte offsets on the AHB-Lite window
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_ID_BASE  = 12'h000; // words 0..255 at 4-byte steps
  localparam logic [11:0] OFF_GEOM     = 12'h400; // current cylinders, heads, sectors
  localparam logic [11:0] OFF_MULT     = 12'h404; // multiple-sector count and enable
  localparam logic [11:0] OFF_DMA      = 12'h408; // active multiword dma mode
  localparam logic [11:0] OFF_SEC      = 12'h40C; // security status
  localparam logic [11:0] OFF_CAP      = 12'h410; // lba sector count
  localparam logic [11:0] OFF_STAT     = 12'h414; // read-only block state
  localparam logic [11:0] OFF_STR_BASE = 12'h500; // serial, firmware, model words

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int GEOM_CYL_LSB  = 0;
  localparam int GEOM_HEAD_LSB = 16;
  localparam int GEOM_SPT_LSB  = 24;
  localparam int MULT_EN_BIT   = 8;
  localparam int SEC_LEVEL_BIT = 8;
  localparam int STAT_VLD_BIT  = 0;
  localparam int STAT_GEO_BIT  = 1;
  localparam int STAT_CHK_LSB  = 8;

  // ----------------------------------------------------------------
  // identify word indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IX_GENCFG  = 8'h00;
  localparam logic [7:0] IX_CYL     = 8'h01;
  localparam logic [7:0] IX_SPECCFG = 8'h02;
  localparam logic [7:0] IX_HEADS   = 8'h03;
  localparam logic [7:0] IX_SPT     = 8'h06;
  localparam logic [7:0] IX_SERIAL  = 8'h0A; // 10 words
  localparam logic [7:0] IX_FWREV   = 8'h17; // 4 words
  localparam logic [7:0] IX_MODEL   = 8'h1B; // 20 words
  localparam logic [7:0] IX_MULTMAX = 8'h2F;
  localparam logic [7:0] IX_CAPS    = 8'h31;
  localparam logic [7:0] IX_CAPS2   = 8'h32;
  localparam logic [7:0] IX_PIOMODE = 8'h33;
  localparam logic [7:0] IX_VALID   = 8'h35;
  localparam logic [7:0] IX_CURCYL  = 8'h36;
  localparam logic [7:0] IX_CURHEAD = 8'h37;
  localparam logic [7:0] IX_CURSPT  = 8'h38;
  localparam logic [7:0] IX_CURCAPL = 8'h39;
  localparam logic [7:0] IX_CURCAPH = 8'h3A;
  localparam logic [7:0] IX_MULTCUR = 8'h3B;
  localparam logic [7:0] IX_LBAL    = 8'h3C;
  localparam logic [7:0] IX_LBAH    = 8'h3D;
  localparam logic [7:0] IX_MWDMA   = 8'h3F;
  localparam logic [7:0] IX_ADVPIO  = 8'h40;
  localparam logic [7:0] IX_DMAMIN  = 8'h41;
  localparam logic [7:0] IX_DMAREC  = 8'h42;
  localparam logic [7:0] IX_PIOMIN  = 8'h43;
  localparam logic [7:0] IX_RMSN    = 8'h7F;
  localparam logic [7:0] IX_SECST   = 8'h80;
  localparam logic [7:0] IX_CFAPWR  = 8'hA0;
  localparam logic [7:0] IX_SCANEND = 8'hFE;
  localparam logic [7:0] IX_INTEG   = 8'hFF;
  localparam int         STR_WORDS  = 34;

  // ----------------------------------------------------------------
  // fixed words and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] W_GENCFG   = 16'h0040;
  localparam logic [15:0] W_SPECCFG  = 16'hC837;
  localparam logic [15:0] W_CAPS     = 16'h2F00;
  localparam logic [15:0] W_CAPS2    = 16'h4000;
  localparam logic [15:0] W_PIOMODE  = 16'h0200;
  localparam logic [7:0]  W_MULT_HI  = 8'h80;
  localparam logic [7:0]  W_DMA_SUP  = 8'h07;
  localparam logic [15:0] W_ADVPIO   = 16'h0003;
  localparam logic [15:0] W_CYCLE_NS = 16'h0078; // 120 ns
  localparam logic [15:0] W_RMSN     = 16'h0000;
  localparam logic [15:0] W_CFAPWR   = 16'h0000;
  localparam logic [7:0]  SIG_BYTE   = 8'hA5;
  localparam logic [15:0] CYL_DEF    = 16'h3FFF; // 16383
  localparam logic [7:0]  HEADS_DEF  = 8'h10;
  localparam logic [7:0]  SPT_DEF    = 8'h3F;
  localparam logic [7:0]  MULT_DEF   = 8'h10;
  localparam logic        MULT_EN_DEF = 1'b1;
  localparam logic [1:0]  DMA_DEF    = 2'h2;
  localparam logic [8:0]  SEC_DEF    = 9'h000;
  localparam logic [31:0] LBA_LIMIT  = 32'h00FFFFFF;
  localparam logic [31:0] CAP_DEF    = 32'h00FBFC10;
  localparam logic [15:0] STR_DEF    = 16'h2020; // two ascii spaces

  // bus-side state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DATA = 2'b10
  } idg_state_t;

endpackage

// ### rtl/idg_identify.sv
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module idg_identify
  import idg_pkg::*;
#(
  parameter logic [7:0]  MULT_MAX = MULT_DEF,
  parameter logic [31:0] CAP_INIT = CAP_DEF
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  idg_state_t  st_r;
  logic [11:0] a_off_r;
  logic        a_wr_r;
  logic        a_word_r;
  logic        hreadyout_r;
  logic [31:0] hrdata_r;
  logic        hresp_r;
  logic        rd_out_r;     // pulse: read data just placed on hrdata
  logic [7:0]  rd_idx_r;     // identify index of that read
  logic        rd_id_r;      // that read hit the identify window
  logic [15:0] cyl_r;
  logic [7:0]  heads_r;
  logic [7:0]  spt_r;
  logic [7:0]  mult_cnt_r;
  logic        mult_en_r;
  logic [1:0]  dma_mode_r;
  logic [8:0]  sec_r;
  logic [31:0] cap_r;
  logic [15:0] str_r [STR_WORDS];
  logic [7:0]  scan_idx_r;
  logic [7:0]  sum_r;
  logic [7:0]  chk_r;
  logic [7:0]  sum_last_r;
  logic        chk_vld_r;
  logic [15:0] id_w [256];
  logic        accept;
  logic        in_id;
  logic        hold_chk;
  logic        fin;
  logic        wr_fire;
  logic        geo_ok;
  logic [31:0] chs_prod;
  logic [31:0] lba_cnt;
  logic [31:0] rd_val;
  logic [7:0]  scan_sum;

  assign hreadyout = hreadyout_r;
  assign hrdata    = hrdata_r;
  assign hresp     = hresp_r;

  // ----------------------------------------------------------------
  // bus transfer control
  // ----------------------------------------------------------------
  assign accept   = hsel && hready && htrans[1];
  assign in_id    = (a_off_r[11:10] == OFF_ID_BASE[11:10]);
  // the integrity word is held off until a fresh checksum exists
  assign hold_chk = !a_wr_r && in_id && (a_off_r[9:2] == IX_INTEG) && !chk_vld_r;
  assign fin      = (st_r == ST_DATA) && !hold_chk;
  assign wr_fire  = fin && a_wr_r && a_word_r;

  // address phase capture and one wait state per data phase, more while an integrity word read is held off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r        <= ST_IDLE;
      a_off_r     <= 12'h000;
      a_wr_r      <= 1'b0;
      a_word_r    <= 1'b0;
      hreadyout_r <= 1'b1;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          if (accept) begin
            a_off_r     <= haddr[11:0];
            a_wr_r      <= hwrite;
            a_word_r    <= (hsize == 3'h2);
            hreadyout_r <= 1'b0;
            st_r        <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (fin) begin
            hreadyout_r <= 1'b1;
            st_r        <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // read data, always an okay response
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
      hresp_r  <= 1'b0;
      rd_out_r <= 1'b0;
      rd_idx_r <= 8'h00;
      rd_id_r  <= 1'b0;
    end else begin
      rd_out_r <= fin && !a_wr_r;
      if (fin && !a_wr_r) begin
        hrdata_r <= rd_val;
        rd_idx_r <= a_off_r[9:2];
        rd_id_r  <= in_id;
      end
    end
  end

  // read mux over identify window and control registers
  always_comb begin
    rd_val = 32'h00000000;
    if (in_id) begin
      rd_val = {16'h0000, id_w[a_off_r[9:2]]};
    end else if (a_off_r[11:8] == OFF_STR_BASE[11:8] && a_off_r[7:2] < 6'(STR_WORDS)) begin
      rd_val = {16'h0000, str_r[a_off_r[7:2]]}; // exact page match, no alias above 0x500
    end else begin
      unique case (a_off_r)
        OFF_GEOM: rd_val = {spt_r, heads_r, cyl_r};
        OFF_MULT: rd_val = {23'h000000, mult_en_r, mult_cnt_r};
        OFF_DMA:  rd_val = {30'h00000000, dma_mode_r};
        OFF_SEC:  rd_val = {23'h000000, sec_r};
        OFF_CAP:  rd_val = cap_r;
        OFF_STAT: rd_val = {16'h0000, chk_r, 6'h00, geo_ok, chk_vld_r};
        default:  rd_val = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // software-written settings
  // ----------------------------------------------------------------
  // geometry as set by the initialize-parameters command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyl_r   <= CYL_DEF;
      heads_r <= HEADS_DEF;
      spt_r   <= SPT_DEF;
    end else if (wr_fire && a_off_r == OFF_GEOM) begin
      cyl_r   <= hwdata[GEOM_CYL_LSB +: 16];
      heads_r <= hwdata[GEOM_HEAD_LSB +: 8];
      spt_r   <= hwdata[GEOM_SPT_LSB +: 8];
    end
  end

  // multiple-sector count and enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mult_cnt_r <= MULT_DEF;
      mult_en_r  <= MULT_EN_DEF;
    end else if (wr_fire && a_off_r == OFF_MULT) begin
      mult_cnt_r <= hwdata[7:0];
      mult_en_r  <= hwdata[MULT_EN_BIT];
    end
  end

  // dma mode selected by the feature command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dma_mode_r <= DMA_DEF;
    end else if (wr_fire && a_off_r == OFF_DMA) begin
      dma_mode_r <= hwdata[1:0];
    end
  end

  // security status, level plus six flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_r <= SEC_DEF;
    end else if (wr_fire && a_off_r == OFF_SEC) begin
      sec_r <= {hwdata[SEC_LEVEL_BIT], 2'b00, hwdata[5:0]};
    end
  end

  // lba capacity
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_r <= CAP_INIT;
    end else if (wr_fire && a_off_r == OFF_CAP) begin
      cap_r <= hwdata;
    end
  end

  // string words: serial, firmware revision, model name
  genvar gi;
  generate
    for (gi = 0; gi < STR_WORDS; gi++) begin : g_str
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          str_r[gi] <= STR_DEF;
        end else if (wr_fire && a_off_r == OFF_STR_BASE + 12'(4 * gi)) begin
          str_r[gi] <= hwdata[15:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // identify word image
  // ----------------------------------------------------------------
  assign geo_ok   = (heads_r <= HEADS_DEF) && (spt_r <= SPT_DEF);
  assign chs_prod = 32'(cyl_r) * 32'(heads_r) * 32'(spt_r);
  assign lba_cnt  = (cap_r > LBA_LIMIT) ? LBA_LIMIT : cap_r;

  // every word not named below stays zero
  always_comb begin
    for (int i = 0; i < 256; i++) begin
      id_w[i] = 16'h0000;
    end
    id_w[IX_GENCFG]  = W_GENCFG;
    id_w[IX_CYL]     = CYL_DEF;
    id_w[IX_SPECCFG] = W_SPECCFG;
    id_w[IX_HEADS]   = {8'h00, HEADS_DEF};
    id_w[IX_SPT]     = {8'h00, SPT_DEF};
    // serial fills words 10-19; firmware and model run on from word 23
    for (int i = 0; i < 10; i++) begin
      id_w[IX_SERIAL + 8'(i)] = str_r[i];
    end
    for (int i = 10; i < STR_WORDS; i++) begin
      id_w[IX_FWREV + 8'(i - 10)] = str_r[i];
    end
    id_w[IX_MULTMAX] = {W_MULT_HI, MULT_MAX};
    id_w[IX_CAPS]    = W_CAPS;
    id_w[IX_CAPS2]   = W_CAPS2;
    id_w[IX_PIOMODE] = W_PIOMODE;
    id_w[IX_VALID]   = {13'h0000, 1'b1, 1'b1, geo_ok};
    if (geo_ok) begin
      id_w[IX_CURCYL]  = cyl_r;
      id_w[IX_CURHEAD] = {8'h00, heads_r};
      id_w[IX_CURSPT]  = {8'h00, spt_r};
      id_w[IX_CURCAPL] = {chs_prod[7:0], chs_prod[15:8]};
      id_w[IX_CURCAPH] = {chs_prod[23:16], chs_prod[31:24]};
    end
    id_w[IX_MULTCUR] = {7'h00, mult_en_r, mult_cnt_r};
    id_w[IX_LBAL]    = {lba_cnt[7:0], lba_cnt[15:8]};
    id_w[IX_LBAH]    = {lba_cnt[23:16], lba_cnt[31:24]};
    id_w[IX_MWDMA]   = {5'h00, dma_mode_r == 2'h2, dma_mode_r == 2'h1,
                        dma_mode_r == 2'h0, W_DMA_SUP};
    id_w[IX_ADVPIO]  = W_ADVPIO;
    id_w[IX_DMAMIN]  = W_CYCLE_NS;
    // slower host timing is the host's matter; the word only advertises it
    id_w[IX_DMAREC]  = W_CYCLE_NS;
    id_w[IX_PIOMIN]  = W_CYCLE_NS;
    id_w[IX_RMSN]    = W_RMSN;
    id_w[IX_SECST]   = {7'h00, sec_r};
    id_w[IX_CFAPWR]  = W_CFAPWR;
    id_w[IX_INTEG]   = {chk_r, SIG_BYTE};
  end

  // ----------------------------------------------------------------
  // checksum scanner
  // ----------------------------------------------------------------
  assign scan_sum = sum_r + id_w[scan_idx_r][15:8] + id_w[scan_idx_r][7:0];

  // walks words 0..254; any word-size write restarts it and drops the valid flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scan_idx_r <= 8'h00;
      sum_r      <= 8'h00;
      chk_r      <= 8'h00;
      sum_last_r <= 8'h00;
      chk_vld_r  <= 1'b0;
    end else if (wr_fire) begin
      scan_idx_r <= 8'h00;
      sum_r      <= 8'h00;
      chk_vld_r  <= 1'b0;
    end else if (scan_idx_r == IX_SCANEND) begin
      chk_r      <= 8'h00 - (scan_sum + SIG_BYTE);
      sum_last_r <= scan_sum + SIG_BYTE;
      chk_vld_r  <= 1'b1;
      scan_idx_r <= 8'h00;
      sum_r      <= 8'h00;
    end else begin
      scan_idx_r <= scan_idx_r + 8'h01;
      sum_r      <= scan_sum;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_sig_byte: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_out_r && rd_id_r && rd_idx_r == IX_INTEG |-> hrdata_r[7:0] == 8'hA5)
    else $error("integrity word lacks signature");

  a_chk_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(chk_vld_r) |-> 8'(sum_last_r + chk_r) == 8'h00 && $past(wr_fire) == 1'b0)
    else $error("checksum does not zero the block");

  a_rmsn_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_out_r && rd_id_r && rd_idx_r == IX_RMSN |-> hrdata_r == 32'h00000000)
    else $error("word 127 not zero");

  a_sec_word: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_fire && a_off_r == OFF_SEC |=> id_w[IX_SECST][5:0] == $past(hwdata[5:0]))
    else $error("security word does not follow write");

  a_cfa_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_out_r && rd_id_r && rd_idx_r == IX_CFAPWR |-> hrdata_r == 32'h00000000)
    else $error("word 160 not zero");

  a_gencfg_val: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_out_r && rd_id_r && rd_idx_r == IX_GENCFG |-> hrdata_r == 32'h00000040)
    else $error("word 0 wrong");

  a_speccfg_val: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_out_r && rd_id_r && rd_idx_r == IX_SPECCFG |-> hrdata_r == 32'h0000C837)
    else $error("word 2 wrong");

  a_geom_default: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_out_r && rd_id_r && rd_idx_r == IX_SPT |-> hrdata_r == 32'h0000003F)
    else $error("word 6 wrong");

  a_mult_max: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_out_r && rd_id_r && rd_idx_r == IX_MULTMAX |-> hrdata_r[15:8] == 8'h80)
    else $error("word 47 high byte wrong");

  a_geo_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    heads_r > 8'h10 |-> id_w[IX_VALID][0] == 1'b0 && id_w[IX_CURCAPL] == 16'h0000)
    else $error("oversize geometry still reported");

  a_lba_clamp: assert property (@(posedge hclk) disable iff (!hresetn)
    {id_w[IX_LBAH][7:0], id_w[IX_LBAH][15:8], id_w[IX_LBAL][7:0], id_w[IX_LBAL][15:8]}
      <= 32'h00FFFFFF)
    else $error("lba count above limit");

  a_dma_active: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_fire && a_off_r == OFF_DMA && hwdata[1:0] == 2'h1 |=> id_w[IX_MWDMA] == 16'h0207)
    else $error("dma active bit wrong");

  a_cycle_time: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_out_r && rd_id_r && rd_idx_r == IX_PIOMIN |-> hrdata_r == 32'h00000078)
    else $error("word 67 wrong");

  a_resv_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_out_r && rd_id_r && rd_idx_r > 8'hCD && rd_idx_r < 8'hFF |-> hrdata_r == 32'h00000000)
    else $error("reserved word not zero");

  a_one_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r == ST_IDLE && accept && !(haddr[11:2] == {2'b00, IX_INTEG} && !hwrite)
      |=> !hreadyout_r ##1 hreadyout_r)
    else $error("data phase not one wait state");

endmodule

// ### tb/identify_data_block_generator_tb_top.sv
`timescale 1ns/1ps
module identify_data_block_generator_tb_top;
  import idg_pkg::*;
  // ----------------------------------------------------------------
  // signals and reference state
  // ----------------------------------------------------------------
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout;
  logic        hresp;
  int          fail_count = 0;
  int          num_checks = 0;
  logic [15:0] cyl;
  logic [7:0]  hd;
  logic [7:0]  spt;
  logic [7:0]  mcnt;
  logic        men;
  logic [1:0]  dma;
  logic [8:0]  sec;
  logic [31:0] cap;
  logic [15:0] strw [34];

  idg_identify #(.MULT_MAX(8'h10), .CAP_INIT(32'h00FBFC10)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp)
  );

  idg_host_model host (
    .hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [2:0] sz,
                     input logic [31:0] wd, output logic [31:0] rd);
    logic ok;
    host.xfer(wr, a, sz, wd, rd, ok);
    if (ok !== 1'b1) begin
      fail_count++;
      end_of_test();
    end
  endtask

  function automatic logic [15:0] swp(input logic [15:0] v);
    return {v[7:0], v[15:8]};
  endfunction

  // expected identify word from the reference state
  function automatic logic [15:0] exp_word(input int i);
    logic        gv;
    logic [31:0] p;
    logic [31:0] c;
    gv = (hd <= 8'h10) && (spt <= 8'h3F);
    p = gv ? 32'(cyl) * 32'(hd) * 32'(spt) : 32'h0;
    c = (cap > 32'h00FFFFFF) ? 32'h00FFFFFF : cap;
    case (i)
      0: return 16'h0040;
      1: return 16'h3FFF;
      2: return 16'hC837;
      3: return 16'h0010;
      6: return 16'h003F;
      47: return 16'h8010;
      49: return 16'h2F00;
      50: return 16'h4000;
      51: return 16'h0200;
      53: return {14'h3, gv};
      54: return gv ? cyl : 16'h0;
      55: return gv ? {8'h0, hd} : 16'h0;
      56: return gv ? {8'h0, spt} : 16'h0;
      57: return swp(p[15:0]);
      58: return swp(p[31:16]);
      59: return {7'h0, men, mcnt};
      60: return swp(c[15:0]);
      61: return swp(c[31:16]);
      63: return {5'h0, (dma == 2'h3) ? 3'h0 : 3'(3'h1 << dma), 8'h07};
      64: return 16'h0003;
      65, 66, 67: return 16'h0078;
      128: return {7'h0, sec};
      default: begin
        if (i >= 10 && i <= 19) return strw[i - 10];
        if (i >= 23 && i <= 46) return strw[i - 13];
        return 16'h0;
      end
    endcase
  endfunction

  // read all 256 words, then the byte sum and the state word
  task automatic scan();
    logic [31:0] rd;
    logic [15:0] w;
    logic [7:0]  sum;
    logic [7:0]  es;
    sum = 8'h0;
    es = 8'h0;
    for (int i = 0; i < 256; i++) begin
      bus(1'b0, 12'(i * 4), 3'h2, 32'h0, rd);
      sum = sum + rd[7:0] + rd[15:8];
      w = exp_word(i);
      es = es + w[7:0] + w[15:8];
      if (i < 255) check(rd, {16'h0, w});
      else check(rd, {16'h0, 8'(8'h00 - es - 8'hA5), 8'hA5});
    end
    check({24'h0, sum}, 32'h0);
    bus(1'b0, OFF_STAT, 3'h2, 32'h0, rd);
    w = exp_word(53);
    check(rd, {16'h0, 8'(8'h00 - es - 8'hA5), 6'h0, w[0], 1'b1});
    check({31'h0, hresp}, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic [31:0] wd;
    int          k;
    hresetn = 1'b0;
    void'($urandom(32'h0c2548da));
    {cyl, hd, spt, mcnt, men, dma, sec, cap} = {16'h3FFF, 8'h10, 8'h3F, 8'h10, 1'b1, 2'h2,
                                                9'h0, 32'h00FBFC10};
    foreach (strw[j]) strw[j] = 16'h2020;
    repeat (20) @(posedge hclk);
    check(hrdata, 32'h0);
    check({31'h0, hreadyout}, 32'h1);
    hresetn <= 1'b1;
    scan();
    // refused accesses: identify window write, byte write, unmapped read
    bus(1'b1, OFF_ID_BASE, 3'h2, 32'h0000FFFF, rd);
    bus(1'b1, OFF_GEOM, 3'h0, 32'h01020304, rd);
    bus(1'b0, 12'h600, 3'h2, 32'h0, rd);
    check(rd, 32'h0);
    for (int r = 0; r < 6; r++) begin
      cyl = 16'($urandom);
      hd = (r == 1) ? 8'h11 : (r < 3) ? 8'h10 : 8'($urandom_range(31, 0));
      spt = (r == 2) ? 8'h40 : (r < 3) ? 8'h3F : 8'($urandom_range(127, 0));
      bus(1'b1, OFF_GEOM, 3'h2, {spt, hd, cyl}, rd);
      wd = $urandom;
      {men, mcnt} = wd[8:0];
      bus(1'b1, OFF_MULT, 3'h2, wd, rd);
      wd = $urandom;
      dma = (r < 4) ? 2'(r) : wd[1:0];
      bus(1'b1, OFF_DMA, 3'h2, {wd[31:2], dma}, rd);
      wd = $urandom;
      sec = {wd[8], 2'h0, wd[5:0]};
      bus(1'b1, OFF_SEC, 3'h2, wd, rd);
      cap = (r == 0) ? 32'h00FFFFFF : (r == 1) ? 32'h01000000 : $urandom;
      bus(1'b1, OFF_CAP, 3'h2, cap, rd);
      k = $urandom_range(33, 0);
      wd = $urandom;
      strw[k] = wd[15:0];
      bus(1'b1, OFF_STR_BASE + 12'(k * 4), 3'h2, {16'h0, wd[15:0]}, rd);
      scan();
    end
    end_of_test();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge hclk);
    fail_count++;
    end_of_test();
  end
endmodule

// ### tb/idg_host_model.sv
`timescale 1ns/1ps
module idg_host_model (
  // clock
  input  wire logic        hclk,
  // ahb-lite master side
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  localparam int WAIT_MAX = 400;

  // idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'hA5A5_5A5A;
  end

  // one single transfer; each phase held until hready is seen high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [2:0] sz,
                      input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= wr;
    hsize <= sz;
    hwdata <= ~wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < WAIT_MAX);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~{20'h0, a};
    hwdata <= wr ? wd : ~wd;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < WAIT_MAX);
    rd = hrdata;
    ok = (hready === 1'b1);
  endtask
endmodule
